// *** rtl/fld_dispatch.sv ***
// Floating-point opcode dispatch: aliasing, traps, serialisation and
// an AHB-Lite register slave for the control flags and control word.
// Assumes the fetch side and the unit run on clk; bus has one slave.
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module fld_dispatch (
   input wire logic clk, // Core clock, 100 MHz.
   input wire logic rst, // Asynchronous reset, active high.
   input wire logic hsel, // Slave select.
   input wire logic [31:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write when high.
   input wire logic [2:0] hsize, // Transfer size, word only.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready.
   output logic [31:0] hrdata, // Read data.
   output logic hreadyout, // Slave ready, never stalls.
   output logic hresp, // Always OKAY.
   input wire logic op_valid, // Opcode offered by fetch.
   input wire logic [15:0] op_code, // Opcode, escape byte high.
   output logic op_ready, // Opcode may be taken.
   input wire logic fpu_done, // Unit finished the issued op.
   input wire logic fpu_err, // Unit reports a numeric error.
   output fld_pkg::fld_disp_t disp, // Dispatch result.
   output logic disp_valid, // Dispatch result pulse.
   output logic fp_error // Pending numeric error.
);
   // Alias match on the upper thirteen bits.
   function automatic logic hit(input logic [15:0] op,
                                input logic [15:0] base);
      hit = op[15:3] == base[15:3];
   endfunction

   // Full decode of one opcode against the current flags.
   function automatic fld_pkg::fld_disp_t decode(input logic [15:0] op,
                                                 input logic [4:0] c);
      fld_pkg::fld_disp_t d;
      logic fp;
      d = '{kind: fld_pkg::K_FPU, opcode: op, extra_pop: 1'b0,
            no_underflow: 1'b0, partial_store_ok: 1'b0,
            vector: 8'h00};
      fp = (op[15:11] == fld_pkg::ESC_TOP) || hit(op, fld_pkg::AL_XCH_A);
      if (hit(op, fld_pkg::AL_CMP_A)) begin
         d.opcode = {fld_pkg::DEF_CMP[15:3], op[2:0]};
      end else if (hit(op, fld_pkg::AL_CMPP_A)) begin
         d.opcode = {fld_pkg::DEF_CMPP[15:3], op[2:0]};
      end else if (hit(op, fld_pkg::AL_XCH_A)) begin
         d.opcode = {fld_pkg::DEF_XCH[15:3], op[2:0]};
      end else if (hit(op, fld_pkg::AL_CMPP_B)) begin
         d.opcode = {fld_pkg::DEF_CMPP[15:3], op[2:0]};
      end else if (hit(op, fld_pkg::AL_STP_A)) begin
         d.opcode = {fld_pkg::DEF_STP[15:3], op[2:0]};
      end else if (hit(op, fld_pkg::AL_XCH_B)) begin
         d.opcode = {fld_pkg::DEF_XCH[15:3], op[2:0]};
      end else if (hit(op, fld_pkg::AL_STP_B)) begin
         d.opcode = {fld_pkg::DEF_STP[15:3], op[2:0]};
      end else if (hit(op, fld_pkg::AL_STP_NU)) begin
         d.opcode = {fld_pkg::DEF_STP[15:3], op[2:0]};
         d.no_underflow = 1'b1;
      end else if (hit(op, fld_pkg::AL_FREEP)) begin
         d.opcode = {fld_pkg::DEF_FREE[15:3], op[2:0]};
         d.extra_pop = 1'b1;
      end
      // Stores may leave a half-written operand when the tail faults.
      d.partial_store_ok = hit(d.opcode, fld_pkg::DEF_STP);
      if (op == fld_pkg::OP_IRQ_EN || op == fld_pkg::OP_IRQ_DIS ||
          op == fld_pkg::OP_PROTMODE) begin
         d.kind = fld_pkg::K_NOP;
      end else if (op[15:8] == fld_pkg::OP_WAIT_BYTE) begin
         // Waits only consult task-switched when monitoring is on.
         if (c[fld_pkg::CTRL_MP] && c[fld_pkg::CTRL_TS]) begin
            d.kind = fld_pkg::K_TRAP;
            d.vector = fld_pkg::VEC_DNA;
         end
      end else if (!fp || hit(op, fld_pkg::RSV_A) ||
                   (hit(op, fld_pkg::RSV_B) &&
                    op != fld_pkg::OP_INIT)) begin
         // Initialise shares the faulting row but is a defined op.
         d.kind = fld_pkg::K_UD;
         d.vector = fld_pkg::VEC_UD;
      end else if (c[fld_pkg::CTRL_EM]) begin
         d.kind = fld_pkg::K_TRAP;
         d.vector = fld_pkg::VEC_DNA;
      end
      return d;
   endfunction

   logic [4:0] ctrl;
   logic [4:0] next_ctrl;
   logic [15:0] cw;
   logic [15:0] next_cw;
   logic [7:0] addr_q;
   logic [7:0] next_addr_q;
   logic wr_q;
   logic next_wr_q;
   logic [31:0] next_hrdata;
   logic [15:0] cw_view;
   logic addr_ph;

   fld_pkg::fld_state_t state;
   fld_pkg::fld_state_t next_state;
   fld_pkg::fld_disp_t dec;
   fld_pkg::fld_disp_t next_disp;
   logic next_disp_valid;
   logic next_fp_error;
   logic take;
   logic is_init;

   // The slave answers in zero wait states, so the bus never stalls.
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_ph = hsel && hready && htrans[1];
   // Without a unit, the control word store sees a floating bus.
   assign cw_view = ctrl[fld_pkg::CTRL_PRES] ? cw : fld_pkg::CW_ABSENT;

   // Register decode; read data is prepared in the address phase.
   always_comb begin
      next_addr_q = addr_ph ? haddr[7:0] : addr_q;
      next_wr_q = addr_ph && hwrite;
      next_ctrl = ctrl;
      next_cw = cw;
      next_hrdata = 32'h0000_0000;
      if (wr_q && addr_q == fld_pkg::OFS_CTRL) begin
         next_ctrl = hwdata[4:0];
      end
      if (wr_q && addr_q == fld_pkg::OFS_CW) begin
         next_cw = hwdata[15:0];
      end
      if (take && is_init) begin
         next_cw = fld_pkg::CW_INIT;
      end
      if (addr_ph && !hwrite) begin
         case (haddr[7:0])
            fld_pkg::OFS_CTRL: next_hrdata = {27'h000_0000, ctrl};
            fld_pkg::OFS_STAT: next_hrdata = {26'h000_0000, disp.kind,
                                              fp_error,
                                              state == fld_pkg::S_BUSY};
            fld_pkg::OFS_CW: next_hrdata = {16'h0000, cw_view};
            fld_pkg::OFS_ACC: next_hrdata = {16'h0000,
                                             fld_pkg::ACC_OTHER_HALF_ULP,
                                             fld_pkg::ACC_RNE_HALF_ULP};
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   // Bus-side registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_q <= 8'h00;
         wr_q <= 1'b0;
         ctrl <= fld_pkg::CTRL_RST;
         cw <= fld_pkg::CW_INIT;
         hrdata <= 32'h0000_0000;
      end else begin
         addr_q <= next_addr_q;
         wr_q <= next_wr_q;
         ctrl <= next_ctrl;
         cw <= next_cw;
         hrdata <= next_hrdata;
      end
   end

   // Only one op is in the unit at a time, which gives implicit waits.
   assign op_ready = state == fld_pkg::S_IDLE;
   assign take = op_valid && op_ready;
   assign is_init = op_code == fld_pkg::OP_INIT;
   assign dec = decode(op_code, ctrl);

   // Dispatch, serialisation and the error flag.
   always_comb begin
      next_state = state;
      next_disp = disp;
      next_disp_valid = take;
      next_fp_error = fp_error;
      if (take && is_init) begin
         next_fp_error = 1'b0;
      end
      if (fpu_err) begin
         next_fp_error = 1'b1;
      end
      if (take) begin
         next_disp = dec;
      end
      case (state)
         fld_pkg::S_IDLE: begin
            if (take && dec.kind == fld_pkg::K_FPU) begin
               next_state = fld_pkg::S_BUSY;
            end
         end
         fld_pkg::S_BUSY: begin
            if (fpu_done) begin
               next_state = fld_pkg::S_IDLE;
            end
         end
         default: next_state = fld_pkg::S_IDLE;
      endcase
   end

   // Dispatch registers; reset leaves no error pending.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= fld_pkg::S_IDLE;
         disp <= '0;
         disp_valid <= 1'b0;
         fp_error <= 1'b0;
      end else begin
         state <= next_state;
         disp <= next_disp;
         disp_valid <= next_disp_valid;
         fp_error <= next_fp_error;
      end
   end

   // Checks on the dispatch path.
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_legacy_nop: assert property (
      take && op_code == fld_pkg::OP_PROTMODE |=>
         disp_valid && disp.kind == fld_pkg::K_NOP && state == $past(state))
      else $error("legacy op not a no-op");
   a_alias_cmp: assert property (
      take && hit(op_code, fld_pkg::AL_CMP_A) && !ctrl[fld_pkg::CTRL_EM]
      |=> disp.kind == fld_pkg::K_FPU &&
          disp.opcode == {fld_pkg::DEF_CMP[15:3], $past(op_code[2:0])})
      else $error("compare alias wrong");
   a_alias_stp: assert property (
      take && hit(op_code, fld_pkg::AL_STP_NU) |=>
         disp.no_underflow && disp.opcode[15:3] == fld_pkg::DEF_STP[15:3])
      else $error("store-pop alias wrong");
   a_free_pop: assert property (
      take && hit(op_code, fld_pkg::AL_FREEP) |=> disp.extra_pop)
      else $error("free alias lacks pop");
   a_busy_hold: assert property (
      take && dec.kind == fld_pkg::K_FPU |=>
         !op_ready throughout (##[0:8] fpu_done))
      else $error("op taken while busy");
   a_emul_trap: assert property (
      take && ctrl[fld_pkg::CTRL_EM] && op_code[15:11] == fld_pkg::ESC_TOP
      && dec.kind != fld_pkg::K_NOP && dec.kind != fld_pkg::K_UD
      |=> disp.kind == fld_pkg::K_TRAP && disp.vector == fld_pkg::VEC_DNA)
      else $error("emulation did not trap");
   a_wait_ts: assert property (
      take && op_code[15:8] == fld_pkg::OP_WAIT_BYTE &&
      ctrl[fld_pkg::CTRL_TS] |=>
         (disp.kind == fld_pkg::K_TRAP) == $past(ctrl[fld_pkg::CTRL_MP]))
      else $error("wait ignored monitor flag");
   a_init_clear: assert property (
      take && is_init && !fpu_err |=> !fp_error && cw == fld_pkg::CW_INIT)
      else $error("initialise left error");
   a_cw_absent: assert property (
      addr_ph && !hwrite && haddr[7:0] == fld_pkg::OFS_CW &&
      !ctrl[fld_pkg::CTRL_PRES] |=> hrdata[15:0] == fld_pkg::CW_ABSENT)
      else $error("absent unit control word");
   a_rsv_ud: assert property (
      take && hit(op_code, fld_pkg::RSV_B) && !is_init &&
      op_code != fld_pkg::OP_IRQ_EN && op_code != fld_pkg::OP_IRQ_DIS &&
      op_code != fld_pkg::OP_PROTMODE |=>
         disp.kind == fld_pkg::K_UD && state == fld_pkg::S_IDLE)
      else $error("reserved op not faulted");

   c_alias_issue: cover property (take && hit(op_code, fld_pkg::AL_XCH_B));
   c_busy_done: cover property (state == fld_pkg::S_BUSY ##1 fpu_done);
   c_emul: cover property (take && dec.kind == fld_pkg::K_TRAP);
   c_init: cover property (take && is_init);
endmodule

// *** rtl/fld_pkg.sv ***
// Constants and types for the floating-point opcode dispatch block.
// Assumes one core clock; opcodes arrive as two bytes, escape byte high.
package fld_pkg;
   // Register byte offsets on the AHB-Lite slave.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_CW = 8'h08;
   localparam logic [7:0] OFS_ACC = 8'h0C;
   // Bit positions in the control register.
   localparam int CTRL_EM = 0;
   localparam int CTRL_MP = 1;
   localparam int CTRL_NE = 2;
   localparam int CTRL_TS = 3;
   localparam int CTRL_PRES = 4;
   localparam int CTRL_W = 5;
   localparam logic [4:0] CTRL_RST = 5'h10;
   // Control word values after initialise, with and without the unit.
   localparam logic [15:0] CW_INIT = 16'h037F;
   localparam logic [15:0] CW_ABSENT = 16'hFFFF;
   // Exception vectors.
   localparam logic [7:0] VEC_DNA = 8'h07;
   localparam logic [7:0] VEC_UD = 8'h06;
   // Accuracy bounds in half-ulp units: 1 ulp and 1.5 ulps.
   localparam logic [7:0] ACC_RNE_HALF_ULP = 8'h02;
   localparam logic [7:0] ACC_OTHER_HALF_ULP = 8'h03;
   // Opcodes handled by name.
   localparam logic [15:0] OP_IRQ_EN = 16'hDBE0;
   localparam logic [15:0] OP_IRQ_DIS = 16'hDBE1;
   localparam logic [15:0] OP_PROTMODE = 16'hDBE4;
   localparam logic [15:0] OP_INIT = 16'hDBE3;
   localparam logic [7:0] OP_WAIT_BYTE = 8'h9B;
   localparam logic [4:0] ESC_TOP = 5'h1B;
   // Alias range bases; the low three bits name the stack register.
   localparam logic [15:0] AL_CMP_A = 16'hDCD0;
   localparam logic [15:0] AL_CMPP_A = 16'hDCD8;
   localparam logic [15:0] AL_XCH_A = 16'hD0C8;
   localparam logic [15:0] AL_CMPP_B = 16'hDED0;
   localparam logic [15:0] AL_STP_A = 16'hDFD0;
   localparam logic [15:0] AL_XCH_B = 16'hDFC8;
   localparam logic [15:0] AL_STP_B = 16'hDFD8;
   localparam logic [15:0] AL_STP_NU = 16'hD9D8;
   localparam logic [15:0] AL_FREEP = 16'hDFC0;
   localparam logic [15:0] DEF_CMP = 16'hD8D0;
   localparam logic [15:0] DEF_CMPP = 16'hD8D8;
   localparam logic [15:0] DEF_XCH = 16'hD9C8;
   localparam logic [15:0] DEF_STP = 16'hDDD8;
   localparam logic [15:0] DEF_FREE = 16'hDDC0;
   // Reserved ranges that must fault.
   localparam logic [15:0] RSV_A = 16'hD9D0;
   localparam logic [15:0] RSV_B = 16'hDBE5;

   typedef enum logic [3:0] {
      K_FPU = 4'b0001,
      K_NOP = 4'b0010,
      K_TRAP = 4'b0100,
      K_UD = 4'b1000
   } fld_kind_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_BUSY = 2'b10
   } fld_state_t;

   typedef struct packed {
      fld_kind_t kind;
      logic [15:0] opcode;
      logic extra_pop;
      logic no_underflow;
      logic partial_store_ok;
      logic [7:0] vector;
   } fld_disp_t;
endpackage

// *** dv/fld_unit_model.sv ***
// Behavioural model of the floating-point unit behind the dispatch block.
// Assumes disp and disp_valid are registered on clk; answers each
// unit-bound dispatch with one completion pulse after 1 or 4 cycles.
`timescale 1ns/10ps
module fld_unit_model (
   input wire logic clk, // Core clock.
   input wire logic rst, // Asynchronous reset, active high.
   input fld_pkg::fld_disp_t disp, // Dispatch result from the block.
   input wire logic disp_valid, // Dispatch result pulse.
   input wire logic slow, // Answer after four cycles when high.
   input wire logic err_req, // Report a numeric error with completion.
   output logic fpu_done, // Completion pulse.
   output logic fpu_err // Numeric error pulse.
);
   logic [2:0] cnt;
   logic [2:0] next_cnt;

   // Only unit-bound dispatches start a count; traps and faults never
   // reach the unit, so answering them would hide a busy-state slip.
   always_comb begin
      next_cnt = (cnt != 3'h0) ? cnt - 3'h1 : 3'h0;
      if (disp_valid && disp.kind == fld_pkg::K_FPU) begin
         next_cnt = slow ? 3'h4 : 3'h1;
      end
   end

   // Count register for the completion delay.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 3'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // One pulse as the count expires.
   assign fpu_done = (cnt == 3'h1);
   assign fpu_err = fpu_done & err_req;
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the opcode dispatch block and its registers.
// Assumes one AHB-Lite slave on the bus and the unit model beside it.
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic op_valid = 1'b0;
   logic [15:0] op_code = 16'h0000;
   logic slow = 1'b0;
   logic err_req = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, op_ready, fpu_done, fpu_err, disp_valid, fp_error;
   fld_pkg::fld_disp_t disp;
   int miscompares = 0;
   int n_compared = 0;
   int n_done = 0;
   logic [15:0] src [9];
   logic [15:0] dst [9];
   logic [2:0] fl [9];

   // Free-running core clock at 100 MHz.
   initial begin
      forever #5 clk = ~clk;
   end

   fld_dispatch fld_dispatch_inst (.clk(clk), .rst(rst), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .op_valid(op_valid),
      .op_code(op_code), .op_ready(op_ready), .fpu_done(fpu_done),
      .fpu_err(fpu_err), .disp(disp), .disp_valid(disp_valid),
      .fp_error(fp_error));

   fld_unit_model fld_unit_model_inst (.clk(clk), .rst(rst), .disp(disp),
      .disp_valid(disp_valid), .slow(slow), .err_req(err_req),
      .fpu_done(fpu_done), .fpu_err(fpu_err));

   // Completion pulses seen, used to prove ordering of takes.
   always @(posedge clk) begin
      if (fpu_done === 1'b1) begin
         n_done++;
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask

   // One single AHB-Lite transfer; hready is sampled at each rising edge.
   task automatic ahb(input logic [7:0] a, input logic wr,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check({63'h0, hresp}, 64'h0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      ahb(a, 1'b1, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      ahb(a, 1'b0, 32'h0000_0000, r);
      check(r, exp);
   endtask

   // Offers one opcode, holds it until taken, returns the dispatch.
   task automatic issue(input logic [15:0] op, output fld_pkg::fld_disp_t d);
      @(posedge clk);
      op_valid <= 1'b1;
      op_code <= op;
      do @(posedge clk); while (op_ready !== 1'b1);
      op_valid <= 1'b0;
      @(posedge clk);
      check({63'h0, disp_valid}, 64'h1);
      d = disp;
   endtask

   function automatic fld_pkg::fld_disp_t mk(fld_pkg::fld_kind_t k,
      logic [15:0] op, logic [2:0] f, logic [7:0] v);
      mk = {k, op, f, v};
   endfunction

   task automatic test_end(input string name);
      $display("test %s done", name);
   endtask

   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // The whole run needs some two hundred cycles; this is a hundred times that.
   initial begin
      #200000;
      miscompares++;
      finish_test();
   end

   initial begin
      fld_pkg::fld_disp_t d;
      logic [15:0] lg [3];
      int d0;
      src = '{16'hDCD0, 16'hDCD8, 16'hD0C8, 16'hDED0, 16'hDFD0, 16'hDFC8,
         16'hDFD8, 16'hD9D8, 16'hDFC0};
      // Canonical targets and extra-pop, no-underflow, split-store flags.
      dst = '{16'hD8D0, 16'hD8D8, 16'hD9C8, 16'hD8D8, 16'hDDD8, 16'hD9C8,
         16'hDDD8, 16'hDDD8, 16'hDDC0};
      fl = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h0, 3'h1, 3'h3, 3'h4};
      lg = '{16'hDBE0, 16'hDBE1, 16'hDBE4};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_chk(8'h00, 32'h0000_0010);
      rd_chk(8'h08, 32'h0000_037F);
      rd_chk(8'h0C, 32'h0000_0302);
      wr(8'h10, 32'hFFFF_FFFF);
      rd_chk(8'h10, 32'h0000_0000);
      check({63'h0, fp_error}, 64'h0);
      test_end("reset");
      // Legacy control ops pass as no-ops, also under emulation.
      for (int e = 0; e < 2; e++) begin
         wr(8'h00, e ? 32'h0000_0011 : 32'h0000_0010);
         for (int i = 0; i < 3; i++) begin
            issue(lg[i], d);
            check(d.kind, fld_pkg::K_NOP);
            check({63'h0, op_ready}, 64'h1);
         end
         rd_chk(8'h00, e ? 32'h0000_0011 : 32'h0000_0010);
         rd_chk(8'h08, 32'h0000_037F);
      end
      wr(8'h00, 32'h0000_0010);
      test_end("legacy");
      // Both ends of every alias range, too.
      for (int i = 0; i < 9; i++) begin
         for (int j = 0; j < 8; j += 7) begin
            issue(src[i] + 16'(j), d);
            check(d, mk(fld_pkg::K_FPU, dst[i] + 16'(j), fl[i], 8'h00));
         end
      end
      test_end("alias");
      foreach (lg[i]) begin
         lg[i] = (i == 0) ? 16'hD9D0 : (i == 1) ? 16'hD9D7 : 16'hDBE2;
         issue(lg[i], d);
         check({d.kind, d.vector}, {fld_pkg::K_UD, 8'h06});
      end
      issue(16'h1234, d);
      check(d.kind, fld_pkg::K_UD);
      test_end("reserved");
      // Software without a unit: emulation 1, monitor 0, numeric error 1.
      wr(8'h00, 32'h0000_0005);
      issue(16'hDCD3, d);
      check({d.kind, d.vector}, {fld_pkg::K_TRAP, 8'h07});
      rd_chk(8'h08, 32'h0000_FFFF);
      wr(8'h00, 32'h0000_0012);
      issue(16'hDCD3, d);
      check(d.kind, fld_pkg::K_FPU);
      wr(8'h00, 32'h0000_001A);
      issue(16'h9B00, d);
      check(d.kind, fld_pkg::K_TRAP);
      wr(8'h00, 32'h0000_0018);
      issue(16'h9B00, d);
      check(d.kind, fld_pkg::K_FPU);
      wr(8'h00, 32'h0000_0010);
      test_end("flags");
      // A slow unit must hold the next take until completion.
      slow <= 1'b1;
      issue(16'hDCD0, d);
      d0 = n_done;
      check({63'h0, op_ready}, 64'h0);
      issue(16'hD8D0, d);
      check(n_done - d0, 1);
      slow <= 1'b0;
      test_end("serial");
      // A numeric error stays pending until initialise clears it.
      err_req <= 1'b1;
      issue(16'hDCD0, d);
      repeat (3) @(negedge clk);
      err_req <= 1'b0;
      check({63'h0, fp_error}, 64'h1);
      rd_chk(8'h04, {26'h000_0000, fld_pkg::K_FPU, 2'h2});
      wr(8'h08, 32'h0000_1234);
      rd_chk(8'h08, 32'h0000_1234);
      issue(fld_pkg::OP_INIT, d);
      repeat (6) @(negedge clk);
      check({63'h0, fp_error}, 64'h0);
      rd_chk(8'h08, 32'h0000_037F);
      test_end("init");
      finish_test();
   end
endmodule
